/* File: rfp_map.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 regulator fault-protection block.
 Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register port.
*/
`ifndef RFP_MAP_SVH
`define RFP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RFP_OFF_CTRL      8'h00
`define RFP_OFF_GPO       8'h04
`define RFP_OFF_IRQ       8'h08
`define RFP_OFF_MASK      8'h0c
`define RFP_OFF_STAT      8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RFP_CTRL_EN_LSB   0
`define RFP_CTRL_DIS_LSB  4
`define RFP_CTRL_PINSEL   8
`define RFP_CTRL_SWRST    9
`define RFP_GPO_LVL_LSB   0
`define RFP_GPO_OD_LSB    2
`define RFP_GPO_SEQ_LSB   4
`define RFP_IRQ_SUM_LSB   8
`define RFP_STAT_OVP      4
`define RFP_STAT_TSD      5
`define RFP_STAT_ST_LSB   6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RFP_CTRL_RST      10'h000
`define RFP_GPO_RST       6'h00
`define RFP_MASK_RST      7'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RFP_CLK_MHZ       100
`define RFP_PERSIST_US    1000
`define RFP_PERSIST_CYC   (`RFP_PERSIST_US * `RFP_CLK_MHZ)

`endif

/* File: rfp_pkg.sv */
/*
 Types shared by the regulator fault-protection files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rfp_pkg;

   typedef enum logic [2:0] {
      RFP_SHUTDOWN = 3'b001,
      RFP_STANDBY  = 3'b010,
      RFP_ACTIVE   = 3'b100
   } rfp_state_t;

   // Latched interrupt bits, LSB first: switcher shorts, linear shorts,
   // overvoltage, thermal shutdown, reset event
   typedef struct packed {
      logic       rst_event;
      logic       tsd;
      logic       ovp;
      logic [1:0] lin_short;
      logic [1:0] sw_short;
   } rfp_irq_t;

endpackage : rfp_pkg

/* File: rfp_persist_timer.sv */
/*
 Persistence timer for one regulator output monitor.
 Assumes 'below' is already synchronised to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_persist_timer
   import rfp_pkg::*;
#(
   parameter int unsigned CYCLES = 100000
)(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic below,
   output logic      expired
);
   localparam int W = $clog2(CYCLES + 1);

   logic [W-1:0] cnt_reg;

   // Any rise above threshold or disable restarts from zero
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || !below) begin
         cnt_reg <= '0;
      end else if (cnt_reg != W'(CYCLES)) begin
         cnt_reg <= cnt_reg + W'(1);
      end
   end

   assign expired = run & below & (cnt_reg == W'(CYCLES - 1));

endmodule : rfp_persist_timer
`default_nettype wire

/* File: rfp_top.sv */
/*
 Fault protection and general-output control of a four-regulator power
 manager (two switchers, two linear regulators) with AXI4-Lite registers.
 Assumes monitor and pin inputs are asynchronous and the bus is on aclk.
*/
// Chosen here: the register addresses and the AXI4-Lite register port.
// Functional notes
// - Disabled regulator: switches off, discharge if enabled
// - Below threshold 1 ms after enable: disable
// - Below overload threshold 1 ms: disable regulator
// - Switcher fault: short, summary irq, status, pin
// - Linear fault: short, summary irq, status, pin
// - Clearing short irq retries an enabled regulator
// - Overvoltage disables all at once, gated discharge
// - Overvoltage: outputs low, irq, statuses cleared
// - Overvoltage irq uncleared while condition persists
// - No enable during overvoltage or pending irq
// - Thermal shutdown disables all, irq, standby
// - Thermal irq uncleared while hot; live status
// - No enable during thermal fault or irq
// - Undervoltage: disable, discharge, shutdown; recover standby
// - Unmasked reset irq set after shutdown
// - Software reset reports and restores defaults
// - Second output shares pin with clock input
// - Per output push-pull or open-drain select
// - Level bit sets output unless forced low
// - Per output joins enable-pin sequence
`timescale 1ns/1ps
`default_nettype none
`include "rfp_map.svh"
module rfp_top
   import rfp_pkg::*;
#(
   parameter int unsigned PERSIST_CYCLES = `RFP_PERSIST_CYC,
   parameter logic        RST_MASK_DEF   = 1'b0
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [3:0]  out_below,
   input  wire logic        ovp_pin,
   input  wire logic        tsd_pin,
   input  wire logic        uvlo_pin,
   input  wire logic        en_pin,
   output logic [3:0]       switch_hiz,
   output logic [3:0]       discharge_on,
   output logic             irq_out_n,
   output logic             general_output_a_out,
   output logic             general_output_a_oe_n,
   input  wire logic        general_output_b_in,
   output logic             general_output_b_out,
   output logic             general_output_b_oe_n,
   output logic             external_clock_input,
   output rfp_state_t       dev_state
);
   // -------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------
   logic [8:0] sync1_reg;
   logic [8:0] sync2_reg;
   logic [3:0] below_s;
   logic       ovp_s;
   logic       tsd_s;
   logic       uvlo_s;
   logic       en_s;
   logic       clk_in_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 9'h000;
         sync2_reg <= 9'h000;
      end else begin
         sync1_reg <= {general_output_b_in, en_pin, uvlo_pin, tsd_pin,
                       ovp_pin, out_below};
         sync2_reg <= sync1_reg;
      end
   end

   assign below_s  = sync2_reg[3:0];
   assign ovp_s    = sync2_reg[4];
   assign tsd_s    = sync2_reg[5];
   assign uvlo_s   = sync2_reg[6];
   assign en_s     = sync2_reg[7];
   assign clk_in_s = sync2_reg[8];

   // -------------------------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------------------------
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        do_write;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic        wr_map;
   logic        rd_map;
   logic [31:0] rd_word;

   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready  = !w_hold_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_hold_reg & w_hold_reg & !s_axi_bvalid;

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         wmask[8*k +: 8] = {8{wstrb_reg[k]}};
      end
   end

   assign wbits  = wdata_reg & wmask;
   assign wr_map = (awaddr_reg == `RFP_OFF_CTRL) || (awaddr_reg == `RFP_OFF_GPO)
                || (awaddr_reg == `RFP_OFF_IRQ) || (awaddr_reg == `RFP_OFF_MASK)
                || (awaddr_reg == `RFP_OFF_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end else if (do_write) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (do_write) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   logic [9:0]  ctrl_reg;
   logic [5:0]  gpo_reg;
   logic [6:0]  mask_reg;
   rfp_irq_t    irq_reg;
   rfp_irq_t    irq_next;
   rfp_irq_t    irq_set;
   logic [6:0]  irq_clr;
   logic        swrst_reg;
   logic        soft_clear;
   logic [3:0]  en_stat_reg;
   logic [3:0]  en_next;
   logic [3:0]  expired;
   logic        block_all;
   rfp_state_t  state_reg;
   rfp_state_t  state_next;

   // Undervoltage and software reset both return the map to defaults
   assign soft_clear = uvlo_s | swrst_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_clear) begin
         ctrl_reg <= `RFP_CTRL_RST;
         gpo_reg  <= `RFP_GPO_RST;
         mask_reg <= {RST_MASK_DEF, 6'h00} | `RFP_MASK_RST;
      end else if (do_write) begin
         if (awaddr_reg == `RFP_OFF_CTRL) begin
            ctrl_reg <= (ctrl_reg & ~wmask[9:0]) | wbits[9:0];
         end
         if (awaddr_reg == `RFP_OFF_GPO) begin
            gpo_reg <= (gpo_reg & ~wmask[5:0]) | wbits[5:0];
         end
         if (awaddr_reg == `RFP_OFF_MASK) begin
            mask_reg <= (mask_reg & ~wmask[6:0]) | wbits[6:0];
         end
      end else begin
         ctrl_reg[`RFP_CTRL_SWRST] <= 1'b0;
      end
   end

   // Request bit is seen one cycle late so the write itself completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swrst_reg <= 1'b0;
      end else begin
         swrst_reg <= ctrl_reg[`RFP_CTRL_SWRST] & !swrst_reg;
      end
   end

   // -------------------------------------------------------------------
   // Short-circuit and overload timers
   // -------------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_tmr
      rfp_persist_timer #(
         .CYCLES (PERSIST_CYCLES)
      ) rfp_persist_timer_inst (
         .aclk    (aclk),
         .aresetn (aresetn),
         .run     (en_stat_reg[i]),
         .below   (below_s[i]),
         .expired (expired[i])
      );
   end

   // -------------------------------------------------------------------
   // Interrupt bits
   // -------------------------------------------------------------------
   always_comb begin
      irq_set           = '0;
      irq_set.sw_short  = expired[1:0];
      irq_set.lin_short = expired[3:2];
      irq_set.ovp       = ovp_s;
      irq_set.tsd       = tsd_s;
      irq_set.rst_event = swrst_reg
                        | ((state_reg == RFP_SHUTDOWN) && !uvlo_s && !mask_reg[6]);
      irq_clr = (do_write && awaddr_reg == `RFP_OFF_IRQ) ? wbits[6:0] : 7'h00;
   end

   // Set wins over a simultaneous write-one clear
   always_comb begin
      if (uvlo_s) begin
         irq_next = '0;
      end else begin
         irq_next = rfp_irq_t'((irq_reg & ~irq_clr) | irq_set);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= ~|(irq_reg & ~mask_reg);
      end
   end

   // -------------------------------------------------------------------
   // Regulator enables and power stage control
   // -------------------------------------------------------------------
   assign block_all = ovp_s | irq_reg.ovp | tsd_s | irq_reg.tsd | uvlo_s;

   // A cleared short bit with the request still set starts a new attempt
   always_comb begin
      en_next = ctrl_reg[3:0] & ~{irq_reg.lin_short, irq_reg.sw_short}
              & ~expired & {4{!block_all}};
      if (state_reg == RFP_SHUTDOWN) begin
         en_next = 4'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_stat_reg <= 4'h0;
      end else begin
         en_stat_reg <= en_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         switch_hiz   <= 4'hf;
         discharge_on <= 4'h0;
      end else begin
         switch_hiz <= ~en_next;
         if (uvlo_s || state_reg == RFP_SHUTDOWN) begin
            discharge_on <= 4'hf;
         end else begin
            discharge_on <= ~en_next & ctrl_reg[7:4];
         end
      end
   end

   // -------------------------------------------------------------------
   // Device state
   // -------------------------------------------------------------------
   always_comb begin
      case (state_reg)
         RFP_SHUTDOWN: state_next = RFP_STANDBY;
         RFP_STANDBY:  state_next = (|en_next) ? RFP_ACTIVE : RFP_STANDBY;
         RFP_ACTIVE:   state_next = (|en_next && !tsd_s) ? RFP_ACTIVE : RFP_STANDBY;
         default:      state_next = RFP_SHUTDOWN;
      endcase
      if (uvlo_s) begin
         state_next = RFP_SHUTDOWN;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= RFP_SHUTDOWN;
      end else begin
         state_reg <= state_next;
      end
   end

   assign dev_state = state_reg;

   // -------------------------------------------------------------------
   // General outputs
   // -------------------------------------------------------------------
   logic       force_low;
   logic [1:0] lvl;

   assign force_low = ovp_s | irq_reg.ovp | uvlo_s;

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         lvl[k] = gpo_reg[`RFP_GPO_LVL_LSB + k]
                & (en_s | !gpo_reg[`RFP_GPO_SEQ_LSB + k]) & !force_low;
      end
   end

   // Open drain only ever pulls low; the pin is released for a high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         general_output_a_out  <= 1'b0;
         general_output_a_oe_n <= 1'b1;
         general_output_b_out  <= 1'b0;
         general_output_b_oe_n <= 1'b1;
         external_clock_input  <= 1'b0;
      end else begin
         general_output_a_out  <= lvl[0] & !gpo_reg[`RFP_GPO_OD_LSB];
         general_output_a_oe_n <= lvl[0] & gpo_reg[`RFP_GPO_OD_LSB];
         if (ctrl_reg[`RFP_CTRL_PINSEL]) begin
            general_output_b_out  <= 1'b0;
            general_output_b_oe_n <= 1'b1;
            external_clock_input  <= clk_in_s;
         end else begin
            general_output_b_out  <= lvl[1] & !gpo_reg[`RFP_GPO_OD_LSB + 1];
            general_output_b_oe_n <= lvl[1] & gpo_reg[`RFP_GPO_OD_LSB + 1];
            external_clock_input  <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_map  = 1'b1;
      case (s_axi_araddr)
         `RFP_OFF_CTRL: rd_word[9:0] = ctrl_reg;
         `RFP_OFF_GPO:  rd_word[5:0] = gpo_reg;
         `RFP_OFF_MASK: rd_word[6:0] = mask_reg;
         `RFP_OFF_IRQ: begin
            rd_word[6:0] = irq_reg;
            rd_word[`RFP_IRQ_SUM_LSB +: 4] = {irq_reg.lin_short, irq_reg.sw_short};
         end
         `RFP_OFF_STAT: begin
            rd_word[3:0] = en_stat_reg;
            rd_word[`RFP_STAT_OVP] = ovp_s;
            rd_word[`RFP_STAT_TSD] = tsd_s;
            rd_word[`RFP_STAT_ST_LSB +: 3] = state_reg;
         end
         default: rd_map = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_map ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   fault_disable_a: assert property (expired[0] |=> !en_stat_reg[0] && irq_reg.sw_short[0])
      else $error("switcher fault did not disable");
   lin_fault_a: assert property (expired[3] |=> !en_stat_reg[3] ##1 !irq_out_n || mask_reg[3])
      else $error("linear fault not reported");
   sw_pin_a: assert property (expired[1] && !mask_reg[1] |=> ##1 !irq_out_n)
      else $error("switcher fault pin not low");
   discharge_gate_a: assert property (state_reg != RFP_SHUTDOWN && !uvlo_s
      |=> (discharge_on & en_stat_reg) == 4'h0)
      else $error("discharge with regulator on");
   ovp_off_a: assert property (ovp_s |=> en_stat_reg == 4'h0 && irq_reg.ovp)
      else $error("overvoltage did not disable");
   ovp_hold_a: assert property (ovp_s && irq_reg.ovp |=> irq_reg.ovp)
      else $error("overvoltage irq cleared early");
   ovp_gpo_a: assert property (ovp_s |=> ##1 !general_output_a_out)
      else $error("output high during overvoltage");
   ovp_block_a: assert property (irq_reg.ovp |=> en_stat_reg == 4'h0)
      else $error("enable during overvoltage irq");
   tsd_hold_a: assert property (tsd_s && irq_reg.tsd |=> irq_reg.tsd)
      else $error("thermal irq cleared early");
   tsd_block_a: assert property (irq_reg.tsd |=> en_stat_reg == 4'h0)
      else $error("enable during thermal irq");
   tsd_standby_a: assert property (tsd_s && state_reg == RFP_ACTIVE && !uvlo_s
      |=> state_reg == RFP_STANDBY)
      else $error("thermal shutdown kept active");
   uvlo_shut_a: assert property (uvlo_s |=> state_reg == RFP_SHUTDOWN
      && discharge_on == 4'hf)
      else $error("undervoltage not in shutdown");
   irq_pin_a: assert property ((irq_reg & ~mask_reg) != 7'h00 |=> !irq_out_n)
      else $error("interrupt pin not asserted");

endmodule : rfp_top
`default_nettype wire

/* File: rfp_monitor_model.sv */
/*
 Analog side of the fault block: regulator outputs that ramp after their
 switches close, and the shared pin of the second general output.
 Assumes the bench drives short_cmd to put a fault on an output.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_monitor_model #(
   parameter int RAMP = 3
)(
   input  wire logic       aclk,
   input  wire logic [3:0] switch_hiz,
   input  wire logic [3:0] short_cmd,
   input  wire logic       pin_b_out,
   input  wire logic       pin_b_oe_n,
   input  wire logic       ext_level,
   output logic [3:0]      out_below,
   output logic            pin_b
);
   int unsigned ramp_cnt [4];

   // Ramp is kept under the persistence count so a clean start never trips
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 4; i++) begin
         if (switch_hiz[i]) ramp_cnt[i] <= RAMP;
         else if (ramp_cnt[i] != 0) ramp_cnt[i] <= ramp_cnt[i] - 1;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         out_below[i] = switch_hiz[i] | short_cmd[i] | (ramp_cnt[i] != 0);
      end
   end

   // Released pin shows what the outside world drives
   assign pin_b = pin_b_oe_n ? ext_level : pin_b_out;
endmodule : rfp_monitor_model
`default_nettype wire

/* File: rfp_top_test.sv */
/*
 Self-checking bench of rfp_top: register access, monitor faults, outputs.
 Assumes rfp_monitor_model on the analog side and a short persistence count.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_top_test
   import rfp_pkg::*;
();
   localparam int PC = 20;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq_n, ext_lvl, ext_clk;
   logic        ovp, tsd, uvlo, en_pin, ga, ga_oe_n, gb, gb_oe_n, gb_pin;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   logic [3:0]  below, hiz, dis, sc;
   logic [11:0] tbl [9];
   rfp_state_t  st;
   int          n_errors, check_count, cyc;

   rfp_top #(.PERSIST_CYCLES(PC)) rfp_top_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .out_below(below), .ovp_pin(ovp), .tsd_pin(tsd), .uvlo_pin(uvlo), .en_pin(en_pin),
      .switch_hiz(hiz), .discharge_on(dis), .irq_out_n(irq_n),
      .general_output_a_out(ga), .general_output_a_oe_n(ga_oe_n),
      .general_output_b_in(gb_pin), .general_output_b_out(gb),
      .general_output_b_oe_n(gb_oe_n), .external_clock_input(ext_clk), .dev_state(st));
   rfp_monitor_model rfp_monitor_model_inst (
      .aclk(aclk), .switch_hiz(hiz), .short_cmd(sc), .pin_b_out(gb),
      .pin_b_oe_n(gb_oe_n), .ext_level(ext_lvl), .out_below(below), .pin_b(gb_pin));

   // ------------------------------------------------------------
   // Clock, watchdog, shared tasks
   // ------------------------------------------------------------
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask : cy

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   // Handshakes are seen at the falling edge, acted on at the next rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         {aw, w, b} = {awvalid & awready, wvalid & wready, bvalid};
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
         if (b) rs = bresp;
      end while (!b);
      @(posedge aclk);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      logic ar, r;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         {ar, r} = {arvalid & arready, rvalid};
         @(posedge aclk);
         if (r) {rd, rs} = {rdata, rresp};
         if (ar) arvalid <= 1'b0;
         if (r) rready <= 1'b0;
      end while (!r);
      @(posedge aclk);
   endtask : rdr

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      cy(3);
      chk(32'(st), 32'(RFP_STANDBY), "state after reset");
      rdr(8'h08);
      chk(32'(rd[6]), 32'h1, "reset event");
      chk(32'(irq_n), 32'h0, "pin asserted");
      wr(8'h0c, 32'h40);
      cy(3);
      chk(32'(irq_n), 32'h1, "masked bit releases pin");
      wr(8'h08, 32'h40);
      wr(8'h0c, 32'h0);
      rdr(8'h1c);
      chk(32'(rs), 32'h2, "unmapped read");
      wr(8'h1c, 32'h0);
      chk(32'(rs), 32'h2, "unmapped write");
      $display("reset test done");
   endtask : t_reset

   // Index 0 is a switcher with discharge enabled, 3 a linear one without
   task automatic t_short(input int i);
      wr(8'h00, 32'(1 << i) | 32'h10);
      cy(10);
      chk(32'(hiz[i]), 32'h0, "regulator on");
      sc[i] <= 1'b1;
      cy(PC - 4);
      sc[i] <= 1'b0;
      cy(1);
      sc[i] <= 1'b1;
      cy(PC - 4);
      chk(32'(hiz[i]), 32'h0, "timer restarted");
      cy(10);
      chk(32'(hiz[i]), 32'h1, "short trips");
      chk(32'(dis[i]), 32'(i == 0), "gated discharge");
      chk(32'(irq_n), 32'h0, "pin asserted");
      rdr(8'h08);
      chk(32'({rd[8 + i], rd[i]}), 32'h3, "short and summary");
      rdr(8'h10);
      chk(32'(rd[i]), 32'h0, "enabled status");
      sc[i] <= 1'b0;
      wr(8'h08, 32'(1 << i));
      cy(10);
      chk(32'(hiz[i]), 32'h0, "new start-up");
      chk(32'(irq_n), 32'h1, "pin released");
      wr(8'h00, 32'h0);
      $display("short test done");
   endtask : t_short

   // p = 0 overvoltage, p = 1 thermal shutdown
   task automatic t_fault(input int p);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h2f);
      cy(10);
      chk(32'(ga), 32'h1, "level driven");
      if (p == 0) ovp <= 1'b1;
      else tsd <= 1'b1;
      cy(6);
      chk(32'(hiz), 32'hf, "all off");
      chk(32'(dis), 32'h2, "gated discharge");
      chk(32'(irq_n), 32'h0, "pin asserted");
      if (p == 0) chk(32'(ga), 32'h0, "output forced low");
      else chk(32'(st), 32'(RFP_STANDBY), "standby");
      rdr(8'h10);
      chk(32'({rd[4 + p], rd[3:0]}), 32'h10, "live bit, statuses");
      wr(8'h08, 32'(16 << p));
      rdr(8'h08);
      chk(32'(rd[4 + p]), 32'h1, "clear refused");
      if (p == 0) ovp <= 1'b0;
      else tsd <= 1'b0;
      cy(6);
      chk(32'(hiz), 32'hf, "enable refused");
      wr(8'h08, 32'(16 << p));
      rdr(8'h08);
      chk(32'(rd[4 + p]), 32'h0, "cleared");
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      $display("fault test done");
   endtask : t_fault

   // Entry: [11:6] register, [5] enable pin, [3:0] a out, a oe_n, b out, b oe_n
   task automatic t_gpo;
      tbl = '{12'h048, 12'h000, 12'h144, 12'h100, 12'h440, 12'h468, 12'h082,
              12'h281, 12'h880};
      for (int k = 0; k < 9; k++) begin
         en_pin <= tbl[k][5];
         wr(8'h04, 32'(tbl[k][11:6]));
         cy(6);
         chk(32'({ga, ga_oe_n, gb, gb_oe_n}), 32'(tbl[k][3:0]), "outputs");
      end
      wr(8'h00, 32'h100);
      ext_lvl <= 1'b1;
      cy(6);
      chk(32'({ext_clk, gb_oe_n}), 32'h3, "clock input");
      wr(8'h00, 32'h0);
      cy(6);
      chk(32'(ext_clk), 32'h0, "output selected");
      $display("output test done");
   endtask : t_gpo

   task automatic t_power;
      wr(8'h04, 32'h3f);
      wr(8'h00, 32'h201);
      cy(4);
      rdr(8'h00);
      chk(rd, 32'h0, "control default");
      rdr(8'h04);
      chk(rd, 32'h0, "output default");
      rdr(8'h08);
      chk(32'(rd[6]), 32'h1, "reset event");
      wr(8'h08, 32'h40);
      wr(8'h00, 32'h1);
      cy(10);
      uvlo <= 1'b1;
      cy(5);
      chk(32'({st, hiz, dis}), 32'({RFP_SHUTDOWN, 8'hff}), "shutdown");
      uvlo <= 1'b0;
      cy(5);
      chk(32'(st), 32'(RFP_STANDBY), "standby");
      rdr(8'h08);
      chk(32'(rd[6]), 32'h1, "reset event");
      $display("power test done");
   endtask : t_power

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, ovp, tsd, uvlo, en_pin, ext_lvl} = '0;
      {awaddr, araddr, wdata, sc} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_short(0);
      t_short(1);
      t_short(3);
      t_fault(0);
      t_fault(1);
      t_gpo();
      t_power();
      report_and_stop();
   end
endmodule : rfp_top_test
`default_nettype wire
